/* rtl/system_clock_select_divider.sv */
// Purpose: System clock source select, 1.5 prescale, power-of-two divide, trims
// Assumes: Oscillator edges arrive as one-cycle ticks synchronous to core_clk
// Notes: core_clock_en is the system clock as an enable pulse
// Behaviour
// - Reset selects first fast oscillator with divide by eight.
// - Source field picks oscillator; divider output is the system clock.
// - System divider offers eight settings, 1 up to 128.
// - Both fast oscillators offer an extra divide by 1.5.
// - Source and divide may change at any time.
// - External clock is always resynchronised when clocking peripherals.
// - Fast oscillators start automatically when selected as source.
// - Each fast oscillator period follows its writable trim register.
// - Slow oscillator has output divider 1, 2, 4 or 8.
// - Slow oscillator has a writable coarse trim field.
// - Slow oscillator usable as system clock right after enable write.
// - Timer capture mode copies count on each tick out of the slow oscillator output divider.
// - Source codes 0,1,2,3,4,7 as fast a, external, slow, fast b, a/1.5, b/1.5.
// - Divide codes 0 to 7 give 1, 2, 4 up to 128.
`timescale 1ns/1ns
`include "clk_sel_regs.svh"
module system_clock_select_divider
  import clk_sel_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic fast_osc_a_tick,
  input wire logic fast_osc_b_tick,
  input wire logic slow_osc_tick,
  input wire logic external_clock_in,
  input wire logic [7:0] factory_trim_a,
  input wire logic [6:0] factory_trim_b,
  input wire logic capture_mode,
  input wire logic [15:0] timer_count,
  output logic core_clock_en,
  output logic ext_periph_tick,
  output logic fast_osc_a_run,
  output logic fast_osc_b_run,
  output logic slow_osc_run,
  output logic [7:0] fast_osc_a_trim,
  output logic [6:0] fast_osc_b_trim,
  output logic [3:0] slow_osc_coarse_trim,
  output logic capture_pulse,
  output logic [15:0] reload_value
);

  // Register state
  src_code_t source_choice_field_r;
  src_code_t source_choice_field_nxt;
  logic [2:0] divide_choice_field_r;
  logic [2:0] divide_choice_field_nxt;
  logic [7:0] fast_a_trim_r;
  logic [7:0] fast_a_trim_nxt;
  logic [6:0] fast_b_trim_r;
  logic [6:0] fast_b_trim_nxt;
  logic [7:0] slow_osc_control_r;
  logic [7:0] slow_osc_control_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  logic wr_choice;
  logic wr_slow;
  logic div_restart;
  logic divider_settled_flag;

  assign wr_choice = sfr_wr && (sfr_addr == `CLOCK_CHOICE_ADDR);
  assign wr_slow = sfr_wr && (sfr_addr == `SLOW_CTRL_ADDR);
  assign div_restart = wr_choice &&
    (sfr_wdata[`DIV_MSB:`DIV_LSB] != divide_choice_field_r);

  always_comb
  begin
    source_choice_field_nxt = source_choice_field_r;
    divide_choice_field_nxt = divide_choice_field_r;
    fast_a_trim_nxt = fast_a_trim_r;
    fast_b_trim_nxt = fast_b_trim_r;
    slow_osc_control_nxt = slow_osc_control_r;
    rdata_nxt = rdata_r;
    if (wr_choice)
    begin
      source_choice_field_nxt = sfr_wdata[`SRC_MSB:`SRC_LSB];
      divide_choice_field_nxt = sfr_wdata[`DIV_MSB:`DIV_LSB];
    end
    if (sfr_wr && (sfr_addr == `FAST_A_TRIM_ADDR))
    begin
      fast_a_trim_nxt = sfr_wdata;
    end
    if (sfr_wr && (sfr_addr == `FAST_B_TRIM_ADDR))
    begin
      fast_b_trim_nxt = sfr_wdata[6:0];
    end
    if (wr_slow)
    begin
      slow_osc_control_nxt = sfr_wdata;
    end
    if (sfr_rd)
    begin
      unique case (sfr_addr)
        `CLOCK_CHOICE_ADDR:
          rdata_nxt = {divider_settled_flag, divide_choice_field_r, 1'b0,
                       source_choice_field_r};
        `FAST_A_TRIM_ADDR:
          rdata_nxt = fast_a_trim_r;
        `FAST_B_TRIM_ADDR:
          rdata_nxt = {1'b0, fast_b_trim_r};
        `SLOW_CTRL_ADDR:
          rdata_nxt = slow_osc_control_r;
        default:
          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      source_choice_field_r <= `SRC_RESET;
      divide_choice_field_r <= `DIV_RESET;
      fast_a_trim_r <= factory_trim_a;
      fast_b_trim_r <= factory_trim_b;
      slow_osc_control_r <= `SLOW_CTRL_RESET;
      rdata_r <= 8'h00;
    end
    else
    begin
      source_choice_field_r <= source_choice_field_nxt;
      divide_choice_field_r <= divide_choice_field_nxt;
      fast_a_trim_r <= fast_a_trim_nxt;
      fast_b_trim_r <= fast_b_trim_nxt;
      slow_osc_control_r <= slow_osc_control_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // External input resync and 1.5 prescalers
  logic ext_meta_r;
  logic ext_sync_r;
  logic ext_prev_r;
  logic ext_rise;
  logic [1:0] osc_tick;
  logic [1:0] pre_tick;
  logic [1:0] pre_cnt_r [2];
  logic [1:0] pre_cnt_nxt [2];

  assign ext_rise = ext_sync_r && !ext_prev_r;
  assign osc_tick = {fast_osc_b_tick, fast_osc_a_tick};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_prescale
      // Two ticks out per three in, so the average rate is source / 1.5
      assign pre_tick[gi] = osc_tick[gi] && (pre_cnt_r[gi] != 2'h1);
      always_comb
      begin
        pre_cnt_nxt[gi] = pre_cnt_r[gi];
        if (osc_tick[gi])
        begin
          pre_cnt_nxt[gi] = (pre_cnt_r[gi] == `PRESCALE_LAST) ? 2'h0 :
            2'(pre_cnt_r[gi] + 2'h1);
        end
      end
      always_ff @(posedge core_clk)
      begin
        if (sys_rst)
        begin
          pre_cnt_r[gi] <= 2'h0;
        end
        else
        begin
          pre_cnt_r[gi] <= pre_cnt_nxt[gi];
        end
      end
    end
  endgenerate

  // Slow oscillator output divider
  logic slow_div_tick;

  pow2_divider u_slow_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick_in(slow_osc_tick && slow_osc_control_r[`SLOW_EN_BIT]),
    .div_code({1'b0, slow_osc_control_r[`SLOW_DIV_MSB:`SLOW_DIV_LSB]}),
    .restart(1'b0),
    .tick_out(slow_div_tick),
    .settled()
  );

  // Source multiplexer feeding the system divider
  logic src_tick;
  logic sys_tick;

  always_comb
  begin
    unique case (source_choice_field_r)
      `SRC_FAST_A: src_tick = fast_osc_a_tick;
      `SRC_EXTERNAL: src_tick = ext_rise;
      `SRC_SLOW: src_tick = slow_div_tick;
      `SRC_FAST_B: src_tick = fast_osc_b_tick;
      `SRC_FAST_A_PRE: src_tick = pre_tick[0];
      `SRC_FAST_B_PRE: src_tick = pre_tick[1];
      default: src_tick = fast_osc_a_tick;
    endcase
  end

  pow2_divider u_sys_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick_in(src_tick),
    .div_code(divide_choice_field_r),
    .restart(div_restart),
    .tick_out(sys_tick),
    .settled(divider_settled_flag)
  );

  // Output flops
  logic core_clock_en_r;
  logic ext_periph_tick_r;
  logic fast_osc_a_run_r;
  logic fast_osc_b_run_r;
  logic capture_pulse_r;
  logic [15:0] reload_value_r;
  logic [15:0] reload_value_nxt;

  assign reload_value_nxt = (capture_mode && slow_div_tick) ? timer_count :
    reload_value_r;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
      core_clock_en_r <= 1'b0;
      ext_periph_tick_r <= 1'b0;
      fast_osc_a_run_r <= 1'b1;
      fast_osc_b_run_r <= 1'b0;
      capture_pulse_r <= 1'b0;
      reload_value_r <= 16'h0000;
    end
    else
    begin
      ext_meta_r <= external_clock_in;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
      core_clock_en_r <= sys_tick;
      ext_periph_tick_r <= ext_rise;
      fast_osc_a_run_r <= src_is_fast_a(source_choice_field_nxt);
      fast_osc_b_run_r <= src_is_fast_b(source_choice_field_nxt);
      capture_pulse_r <= capture_mode && slow_div_tick;
      reload_value_r <= reload_value_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign core_clock_en = core_clock_en_r;
  assign ext_periph_tick = ext_periph_tick_r;
  assign fast_osc_a_run = fast_osc_a_run_r;
  assign fast_osc_b_run = fast_osc_b_run_r;
  assign slow_osc_run = slow_osc_control_r[`SLOW_EN_BIT];
  assign fast_osc_a_trim = fast_a_trim_r;
  assign fast_osc_b_trim = fast_b_trim_r;
  assign slow_osc_coarse_trim = slow_osc_control_r[`SLOW_TRIM_MSB:`SLOW_TRIM_LSB];
  assign capture_pulse = capture_pulse_r;
  assign reload_value = reload_value_r;

  a_reset_defaults: assert property (@(posedge core_clk)
    sys_rst |=> source_choice_field_r == `SRC_RESET && divide_choice_field_r == `DIV_RESET
      && fast_osc_a_run_r && divider_settled_flag)
    else $error("Reset did not select fast oscillator a divided by eight");

  a_core_en_cause: assert property (@(posedge core_clk) disable iff (sys_rst)
    core_clock_en_r |-> $past(src_tick) && !$past(div_restart))
    else $error("System clock enable without a source tick");

  a_ready_drops: assert property (@(posedge core_clk) disable iff (sys_rst)
    div_restart |=> !divider_settled_flag ##0 !rdata_r[`READY_BIT] || !$past(sfr_rd))
    else $error("Ready flag did not drop on a new divide setting");

  a_div_one_pass: assert property (@(posedge core_clk) disable iff (sys_rst)
    divide_choice_field_r == 3'h0 && src_tick && !div_restart |=> core_clock_en_r)
    else $error("Divide by one did not pass every source tick");

  a_fast_autostart: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_choice && src_is_fast_b(sfr_wdata[`SRC_MSB:`SRC_LSB]) |=> fast_osc_b_run_r
      && !fast_osc_a_run_r)
    else $error("Second fast oscillator not started on selection");

  a_ext_resync: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(ext_sync_r) |=> ext_periph_tick_r ##1 !ext_periph_tick_r)
    else $error("External clock edge not resynchronised to one pulse");

  a_trim_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    sfr_wr && sfr_addr == `FAST_B_TRIM_ADDR |=>
      fast_osc_b_trim == ($past(sfr_wdata) & `FAST_B_TRIM_MASK) >> 0)
    else $error("Fast oscillator b trim not written");

  a_slow_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_slow && sfr_wdata[`SLOW_EN_BIT] |=> slow_osc_run)
    else $error("Slow oscillator not enabled by its write");

  a_capture_copy: assert property (@(posedge core_clk) disable iff (sys_rst)
    capture_mode && slow_div_tick |=> capture_pulse_r && reload_value_r == $past(timer_count))
    else $error("Timer count not captured on slow oscillator edge");

endmodule

/* rtl/clk_sel_regs.svh */
// Purpose: Register offsets, field positions and reset values for the clock selector
// Assumes: Registers sit on the 8-bit special-function register port
// Notes: Definitions only
`ifndef CLK_SEL_REGS_SVH
`define CLK_SEL_REGS_SVH

`define CLOCK_CHOICE_ADDR 8'hA9
`define FAST_A_TRIM_ADDR 8'hC7
`define FAST_B_TRIM_ADDR 8'hD6
`define SLOW_CTRL_ADDR 8'hB1

`define SRC_LSB 0
`define SRC_MSB 2
`define DIV_LSB 4
`define DIV_MSB 6
`define READY_BIT 7

`define SRC_FAST_A 3'h0
`define SRC_EXTERNAL 3'h1
`define SRC_SLOW 3'h2
`define SRC_FAST_B 3'h3
`define SRC_FAST_A_PRE 3'h4
`define SRC_FAST_B_PRE 3'h7

`define SRC_RESET 3'h0
`define DIV_RESET 3'h3

`define SLOW_DIV_LSB 0
`define SLOW_DIV_MSB 1
`define SLOW_TRIM_LSB 2
`define SLOW_TRIM_MSB 5
`define SLOW_EN_BIT 7
`define SLOW_CTRL_RESET 8'h00

`define FAST_B_TRIM_MASK 8'h7F
`define PRESCALE_LAST 2'h2

`endif

/* rtl/clk_sel_pkg.sv */
// Purpose: Types shared by the clock selector files
// Assumes: Offsets and values live in clk_sel_regs.svh
// Notes: Source decode helpers used in several places
package clk_sel_pkg;

  typedef enum logic {
    DIV_PENDING = 1'b0,
    DIV_SETTLED = 1'b1
  } div_state_t;

  typedef logic [2:0] src_code_t;

  function automatic logic src_is_fast_a(input src_code_t src);
    return (src == 3'h0) || (src == 3'h4) || (src == 3'h5) || (src == 3'h6);
  endfunction

  function automatic logic src_is_fast_b(input src_code_t src);
    return (src == 3'h3) || (src == 3'h7);
  endfunction

endpackage

/* rtl/pow2_divider.sv */
// Purpose: Power-of-two tick divider with a settled indication
// Assumes: tick_in is a one-cycle pulse per source edge
// Notes: Divides by 2**div_code, 1 up to 128
`timescale 1ns/1ns
`include "clk_sel_regs.svh"
module pow2_divider
  import clk_sel_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tick_in,
  input wire logic [2:0] div_code,
  input wire logic restart,
  output logic tick_out,
  output logic settled
);

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  div_state_t state_r;
  div_state_t state_nxt;
  logic [6:0] mask;

  assign mask = 7'((8'h01 << div_code) - 8'h01);
  // A count left above a smaller new limit wraps at the next tick
  assign tick_out = tick_in && !restart && (cnt_r >= mask);
  assign settled = (state_r == DIV_SETTLED);

  always_comb
  begin
    cnt_nxt = cnt_r;
    state_nxt = state_r;
    if (restart)
    begin
      cnt_nxt = 7'h00;
      state_nxt = DIV_PENDING;
    end
    else if (tick_in)
    begin
      if (cnt_r >= mask)
      begin
        cnt_nxt = 7'h00;
        state_nxt = DIV_SETTLED;
      end
      else
      begin
        cnt_nxt = 7'(cnt_r + 7'h01);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cnt_r <= 7'h00;
      state_r <= DIV_SETTLED;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      state_r <= state_nxt;
    end
  end

  a_div_count: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick_in && !restart && (cnt_r < mask) |=> cnt_r == 7'($past(cnt_r) + 7'h01))
    else $error("Divider count did not advance");

  a_div_settle: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick_out |=> settled)
    else $error("Divider did not report settled after output tick");

  a_div_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
    restart |=> !settled && cnt_r == 7'h00)
    else $error("Divider restart not taken");

endmodule

/* verif/osc_model.sv */
// Purpose: Oscillator and external clock stand-in
// Assumes: Ticks are one core_clk cycle wide
// Notes: Fast ticks each cycle, slow every other, external period 8
`timescale 1ns/1ns
module osc_model
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic fast_osc_a_run,
  input wire logic fast_osc_b_run,
  input wire logic slow_osc_run,
  output logic fast_osc_a_tick,
  output logic fast_osc_b_tick,
  output logic slow_osc_tick,
  output logic external_clock_in
);
  logic [2:0] phase_r;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      phase_r <= 3'h0;
    else
      phase_r <= phase_r + 3'h1;
  end
  // Stopped oscillators give no ticks
  assign fast_osc_a_tick = fast_osc_a_run;
  assign fast_osc_b_tick = fast_osc_b_run;
  assign slow_osc_tick = slow_osc_run & phase_r[0];
  assign external_clock_in = phase_r[2];
endmodule

/* verif/testbench.sv */
// Purpose: Self-checking bench for the clock selector
// Assumes: Oscillator ticks come from osc_model
// Notes: Read data lands one edge after the strobe
`timescale 1ns/1ns
module testbench;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'h0;
  logic sfr_rd = 1'h0;
  logic [7:0] sfr_wdata = 8'h00;
  logic capture_mode = 1'h0;
  logic [15:0] timer_count = 16'h0000;
  logic [7:0] sfr_rdata, fa_trim;
  logic [6:0] fb_trim;
  logic [3:0] sl_trim;
  logic [15:0] reload_value;
  logic fa_tick, fb_tick, sl_tick, ext_in, clk_en, ext_tick;
  logic fa_run, fb_run, sl_run, cap_pulse;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;

  system_clock_select_divider dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .fast_osc_a_tick(fa_tick), .fast_osc_b_tick(fb_tick),
    .slow_osc_tick(sl_tick), .external_clock_in(ext_in),
    .factory_trim_a(8'h96), .factory_trim_b(7'h2B), .capture_mode(capture_mode),
    .timer_count(timer_count), .core_clock_en(clk_en), .ext_periph_tick(ext_tick),
    .fast_osc_a_run(fa_run), .fast_osc_b_run(fb_run), .slow_osc_run(sl_run),
    .fast_osc_a_trim(fa_trim), .fast_osc_b_trim(fb_trim),
    .slow_osc_coarse_trim(sl_trim), .capture_pulse(cap_pulse),
    .reload_value(reload_value));

  osc_model osc (.core_clk(core_clk), .sys_rst(sys_rst), .fast_osc_a_run(fa_run),
    .fast_osc_b_run(fb_run), .slow_osc_run(sl_run), .fast_osc_a_tick(fa_tick),
    .fast_osc_b_tick(fb_tick), .slow_osc_tick(sl_tick), .external_clock_in(ext_in));

  always #50 core_clk = ~core_clk;

  task automatic stop_test;
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      err_count++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'h1;
    @(posedge core_clk);
    sfr_wr <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'h1;
    @(posedge core_clk);
    sfr_rd <= 1'h0;
    #1;
    d = sfr_rdata;
  endtask

  // Pulses of the system enable or the external tick over n cycles
  task automatic cnt(input int n, input bit ext, output int c);
    c = 0;
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
      if ((ext ? ext_tick : clk_en) === 1'h1)
        c++;
    end
  endtask

  task automatic t_reset;
    logic [7:0] d;
    int c;
    rd(8'hA9, d);
    chk("choice", d, 8'hB0);
    rd(8'hB1, d);
    chk("slow ctrl", d, 8'h00);
    rd(8'h00, d);
    chk("unmapped", d, 8'h00);
    rd(8'hD6, d);
    chk("trim b read", d, 8'h2B);
    chk("trim a", fa_trim, 8'h96);
    chk("a run", fa_run, 1'h1);
    chk("b run", fb_run, 1'h0);
    cnt(64, 1'b0, c);
    chk("reset rate", c, 8);
  endtask

  task automatic t_divide;
    logic [7:0] d;
    int c;
    for (int k = 0; k < 8; k++)
    begin
      wr(8'hA9, {1'h0, 3'(k), 4'h0});
      if (k == 7)
      begin
        rd(8'hA9, d);
        chk("not ready", d[7], 1'h0);
      end
      repeat (8) @(posedge core_clk);
      cnt(256, 1'b0, c);
      chk("div rate", c, 256 >> k);
    end
    rd(8'hA9, d);
    chk("ready", d, 8'hF0);
  endtask

  task automatic t_source;
    logic [2:0] srcs [6] = '{3'h3, 3'h4, 3'h7, 3'h2, 3'h1, 3'h0};
    int wins [6] = '{40, 30, 30, 40, 80, 40};
    int exps [6] = '{40, 20, 20, 20, 10, 40};
    logic [7:0] d;
    int c;
    wr(8'hB1, 8'h80);
    chk("slow run", sl_run, 1'h1);
    for (int k = 0; k < 6; k++)
    begin
      // Fast b gets the same write twice, coming from fast a; external is running
      if (srcs[k] == 3'h3)
        wr(8'hA9, {5'h01, srcs[k]});
      wr(8'hA9, {5'h01, srcs[k]});
      repeat (16) @(posedge core_clk);
      cnt(wins[k], 1'b0, c);
      chk("source rate", c, exps[k]);
      if (srcs[k] == 3'h3)
      begin
        chk("b run", fb_run, 1'h1);
        rd(8'hA9, d);
        chk("reserved bit", d, 8'h83);
      end
      if (srcs[k] == 3'h2)
      begin
        wr(8'hB1, 8'h82);
        repeat (16) @(posedge core_clk);
        cnt(40, 1'b0, c);
        chk("slow div", c, 5);
      end
    end
  endtask

  task automatic t_misc;
    logic [7:0] d;
    int c;
    cnt(80, 1'b1, c);
    chk("ext ticks", c, 10);
    wr(8'hC7, 8'h5A);
    chk("trim a", fa_trim, 8'h5A);
    wr(8'hD6, 8'hFF);
    chk("trim b", fb_trim, 7'h7F);
    rd(8'hD6, d);
    chk("trim b read", d, 8'h7F);
    wr(8'hB1, 8'hBC);
    chk("coarse trim", sl_trim, 4'hF);
    @(posedge core_clk);
    timer_count <= 16'hA5C3;
    capture_mode <= 1'h1;
    c = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      c++;
    end
    while (cap_pulse !== 1'h1 && c < 40);
    chk("capture", cap_pulse, 1'h1);
    chk("reload", reload_value, 16'hA5C3);
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'h0;
    t_reset();
    t_divide();
    t_source();
    t_misc();
    stop_test();
  end
endmodule
